//--- logic/rpssc_top.sv
`timescale 1ns/10ps
`include "rpssc_cfg.svh"
// How it works
// - A two-bit phase field picks where in each ramp period the phase tick falls, phase 0 to 3.
// - With the audio sync bit set, an audio frame pulse restarts the ramp; clear, it is ignored.
// - With the ramp sync bit set, a ramp sync pulse restarts the ramp; clear, it is ignored.
// - In manual mode the pre-divide bit halves the source clock rate of the ramp.
// - The manual bit hands the ramp to the divisor, step, amplitude and limit fields.
// - The random bit adds a random offset to each period, its span set by a three-bit range.
// - The triangle bit sweeps the period up and down, its span set by a four-bit field.
// - In manual mode the period is the eight-bit divisor N ticks, N resetting to 0x50.
// - In manual mode the sweep falls by a four-bit step resetting to 1.
// - In manual mode the sweep rises by a four-bit step resetting to 1.
// - In manual mode the ramp amplitude comes from a two-bit field resetting to 01.
// - In manual mode the sweep is bounded by a five-bit limit resetting to 4.
module rpssc_top
   import rpssc_pkg::*;
(
   // Clock and reset.
   input  wire logic        sys_clk,
   input  wire logic        arst_n,
   // AXI4-Lite write address.
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // AXI4-Lite write data.
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // AXI4-Lite write response.
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read address.
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // AXI4-Lite read data.
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Synchronisation pulses.
   input  wire logic        audioSync,
   input  wire logic        rampSyncIn,
   // Ramp outputs.
   output logic [9:0]       rampCount,
   output logic [9:0]       rampPeriod,
   output logic             rampWrap,
   output logic             rampPhaseTick,
   output logic [1:0]       rampAmplitude
);
   logic [1:0]    rstPipe_ff;
   logic          rstSync_n, spreadOff, halfRate;
   logic          awReady_ff, wReady_ff, bValid_ff, arReady_ff, rValid_ff;
   logic [9:0]    awIdx_ff;
   logic [31:0]   wData_ff;
   logic          wStrb0_ff;
   logic [1:0]    bResp_ff, rResp_ff;
   logic [31:0]   rData_ff;
   logic [7:0]    phaseReg_ff, modeReg_ff, rangeReg_ff;
   logic [7:0]    divisorReg_ff, stepReg_ff, ampBndReg_ff;
   logic          preDivTgl_ff;
   logic [9:0]    rampCnt_ff, period_ff;
   logic          rampWrap_ff, phaseTick_ff;
   logic [1:0]    rampAmp_ff;
   logic [5:0]    triOff_ff;
   rpssc_dir_t    dir_ff;
   logic [6:0]    randWord, rndOff_ff, rndMask;
   logic          doWrite, manual, preDiv, triOn, rdmOn, anySync, srcTick, endOfRamp;
   logic [1:0]    phaseSel;
   logic [3:0]    riseStep, fallStep;
   logic [5:0]    limit;
   rpssc_period_t basePeriod, nxt_period;

   function automatic logic isMapped(input logic [9:0] idx);
      return (idx >= `RPSSC_IDX_PHASE && idx <= `RPSSC_IDX_AMPBND) || idx == `RPSSC_IDX_STATUS;
   endfunction

   function automatic logic [6:0] rangeMask(input logic [2:0] r);
      logic [7:0] m;
      m = (8'h01 << ({1'b0, r} + 4'h1)) - 8'h01;
      return m[6:0];
   endfunction

   function automatic rpssc_period_t phasePoint(input rpssc_period_t p, input logic [1:0] sel);
      return 10'((p >> 2) * {8'h00, sel});
   endfunction

   function automatic rpssc_period_t clampPeriod(input rpssc_period_t p);
      return (p < `RPSSC_MIN_PERIOD) ? `RPSSC_MIN_PERIOD : p;
   endfunction

   // Reset release through two flops; assertion is immediate.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         rstPipe_ff <= 2'h0;
      end else begin
         rstPipe_ff <= {rstPipe_ff[0], 1'b1};
      end
   end
   assign rstSync_n = rstPipe_ff[1];

   // Write channel: address and data are taken in either order, then one response.
   assign doWrite = !awReady_ff && !wReady_ff && !bValid_ff;

   always_ff @(posedge sys_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         awReady_ff <= 1'b1;
         wReady_ff  <= 1'b1;
         bValid_ff  <= 1'b0;
         bResp_ff   <= `RPSSC_RESP_OKAY;
         awIdx_ff   <= 10'h000;
         wData_ff   <= 32'h0000_0000;
         wStrb0_ff  <= 1'b0;
      end else begin
         if (awReady_ff && s_axi_awvalid) begin
            awReady_ff <= 1'b0;
            awIdx_ff   <= s_axi_awaddr[11:2];
         end
         if (wReady_ff && s_axi_wvalid) begin
            wReady_ff <= 1'b0;
            wData_ff  <= s_axi_wdata;
            wStrb0_ff <= s_axi_wstrb[0];
         end
         if (doWrite) begin
            bValid_ff <= 1'b1;
            bResp_ff  <= isMapped(awIdx_ff) ? `RPSSC_RESP_OKAY : `RPSSC_RESP_SLVERR;
         end
         if (bValid_ff && s_axi_bready) begin
            bValid_ff  <= 1'b0;
            awReady_ff <= 1'b1;
            wReady_ff  <= 1'b1;
         end
      end
   end

   // Only the low byte lane holds register bits; other lanes are ignored.
   always_ff @(posedge sys_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         phaseReg_ff   <= `RPSSC_RST_PHASE;
         modeReg_ff    <= `RPSSC_RST_MODE;
         rangeReg_ff   <= `RPSSC_RST_RANGE;
         divisorReg_ff <= `RPSSC_RST_DIVISOR;
         stepReg_ff    <= `RPSSC_RST_STEP;
         ampBndReg_ff  <= `RPSSC_RST_AMPBND;
      end else if (doWrite && wStrb0_ff) begin
         unique case (awIdx_ff)
            `RPSSC_IDX_PHASE:   phaseReg_ff   <= wData_ff[7:0];
            `RPSSC_IDX_MODE:    modeReg_ff    <= wData_ff[7:0];
            `RPSSC_IDX_RANGE:   rangeReg_ff   <= wData_ff[7:0];
            `RPSSC_IDX_DIVISOR: divisorReg_ff <= wData_ff[7:0];
            `RPSSC_IDX_STEP:    stepReg_ff    <= wData_ff[7:0];
            `RPSSC_IDX_AMPBND:  ampBndReg_ff  <= wData_ff[7:0];
            default: ;
         endcase
      end
   end

   // Read channel: one read at a time, data registered on the address handshake.
   always_ff @(posedge sys_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         arReady_ff <= 1'b1;
         rValid_ff  <= 1'b0;
         rData_ff   <= 32'h0000_0000;
         rResp_ff   <= `RPSSC_RESP_OKAY;
      end else begin
         if (arReady_ff && s_axi_arvalid) begin
            arReady_ff <= 1'b0;
            rValid_ff  <= 1'b1;
            rResp_ff   <= isMapped(s_axi_araddr[11:2]) ? `RPSSC_RESP_OKAY : `RPSSC_RESP_SLVERR;
            unique case (s_axi_araddr[11:2])
               `RPSSC_IDX_PHASE:   rData_ff <= {24'h000000, phaseReg_ff};
               `RPSSC_IDX_MODE:    rData_ff <= {24'h000000, modeReg_ff};
               `RPSSC_IDX_RANGE:   rData_ff <= {24'h000000, rangeReg_ff};
               `RPSSC_IDX_DIVISOR: rData_ff <= {24'h000000, divisorReg_ff};
               `RPSSC_IDX_STEP:    rData_ff <= {24'h000000, stepReg_ff};
               `RPSSC_IDX_AMPBND:  rData_ff <= {24'h000000, ampBndReg_ff};
               `RPSSC_IDX_STATUS:  rData_ff <= {15'h0000, dir_ff, triOff_ff, period_ff};
               default:            rData_ff <= 32'h0000_0000;
            endcase
         end
         if (rValid_ff && s_axi_rready) begin
            rValid_ff  <= 1'b0;
            arReady_ff <= 1'b1;
         end
      end
   end

   // Field decode.
   assign phaseSel = phaseReg_ff[`RPSSC_PHASE_SEL_HI:`RPSSC_PHASE_SEL_LO];
   assign manual   = modeReg_ff[`RPSSC_MANUAL_BIT];
   assign preDiv   = modeReg_ff[`RPSSC_PREDIV_BIT];
   assign triOn    = modeReg_ff[`RPSSC_TRIANGLE_BIT];
   assign rdmOn    = modeReg_ff[`RPSSC_RANDOM_BIT];
   assign spreadOff = !triOn && !rdmOn;
   assign anySync  = (phaseReg_ff[`RPSSC_AUDIO_SYNC_BIT] && audioSync) ||
                     (phaseReg_ff[`RPSSC_RAMP_SYNC_BIT] && rampSyncIn);

   // Outside manual mode the sweep uses unit steps and the four-bit field as its limit.
   assign riseStep = manual ? stepReg_ff[`RPSSC_RISE_STEP_HI:`RPSSC_RISE_STEP_LO] : 4'h1;
   assign fallStep = manual ? stepReg_ff[`RPSSC_FALL_STEP_HI:`RPSSC_FALL_STEP_LO] : 4'h1;
   assign limit    = manual ? {1'b0, ampBndReg_ff[`RPSSC_LIMIT_HI:`RPSSC_LIMIT_LO]}
                            : {2'h0, rangeReg_ff[`RPSSC_TRI_CTRL_HI:`RPSSC_TRI_CTRL_LO]};
   assign basePeriod = manual ? {2'h0, divisorReg_ff} : `RPSSC_NOM_PERIOD;

   // Spread terms are summed onto the base; with both off the period stays fixed.
   assign nxt_period = clampPeriod(basePeriod + {4'h0, triOff_ff} + {3'h0, rndOff_ff});

   // The system clock stands in for the PLL clock; the toggle halves the tick rate.
   always_ff @(posedge sys_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         preDivTgl_ff <= 1'b0;
      end else begin
         preDivTgl_ff <= !preDivTgl_ff;
      end
   end
   assign halfRate  = manual && preDiv;
   assign srcTick   = !halfRate || preDivTgl_ff;
   assign endOfRamp = srcTick && (rampCnt_ff >= period_ff - 10'h001);

   // Ramp counter; a sync pulse restarts the period at once, overriding the count.
   always_ff @(posedge sys_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         rampCnt_ff  <= 10'h000;
         period_ff   <= `RPSSC_NOM_PERIOD;
         rampWrap_ff <= 1'b0;
      end else begin
         rampWrap_ff <= anySync || endOfRamp;
         if (anySync || endOfRamp) begin
            rampCnt_ff <= 10'h000;
            period_ff  <= nxt_period;
         end else if (srcTick) begin
            rampCnt_ff <= rampCnt_ff + 10'h001;
         end
      end
   end

   // Phase tick marks the selected quarter of the period for staggered switching.
   always_ff @(posedge sys_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         phaseTick_ff <= 1'b0;
      end else begin
         phaseTick_ff <= srcTick && !anySync
                         && (rampCnt_ff == phasePoint(period_ff, phaseSel));
      end
   end

   // Triangle sweep, advanced once per period.
   always_ff @(posedge sys_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         triOff_ff <= 6'h00;
         dir_ff    <= RPSSC_SWEEP_UP;
      end else if (!triOn) begin
         triOff_ff <= 6'h00;
         dir_ff    <= RPSSC_SWEEP_UP;
      end else if (endOfRamp || anySync) begin
         unique case (dir_ff)
            RPSSC_SWEEP_UP: begin
               if (triOff_ff + {2'h0, riseStep} >= limit) begin
                  triOff_ff <= limit;
                  dir_ff    <= RPSSC_SWEEP_DOWN;
               end else begin
                  triOff_ff <= triOff_ff + {2'h0, riseStep};
               end
            end
            RPSSC_SWEEP_DOWN: begin
               if (triOff_ff <= {2'h0, fallStep}) begin
                  triOff_ff <= 6'h00;
                  dir_ff    <= RPSSC_SWEEP_UP;
               end else begin
                  triOff_ff <= triOff_ff - {2'h0, fallStep};
               end
            end
         endcase
      end
   end

   rpssc_lfsr u_lfsr (
      .sys_clk   (sys_clk),
      .rstSync_n (rstSync_n),
      .advance   (endOfRamp || anySync),
      .randWord  (randWord)
   );

   // Random offset, masked to the programmed span.
   assign rndMask = rangeMask(rangeReg_ff[`RPSSC_RDM_RANGE_HI:`RPSSC_RDM_RANGE_LO]);
   always_ff @(posedge sys_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         rndOff_ff <= 7'h00;
      end else begin
         rndOff_ff <= rdmOn ? (randWord & rndMask) : 7'h00;
      end
   end

   always_ff @(posedge sys_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         rampAmp_ff <= `RPSSC_AUTO_AMP;
      end else begin
         rampAmp_ff <= manual ? ampBndReg_ff[`RPSSC_AMP_HI:`RPSSC_AMP_LO]
                              : `RPSSC_AUTO_AMP;
      end
   end

   assign s_axi_awready = awReady_ff;
   assign s_axi_wready  = wReady_ff;
   assign s_axi_bvalid  = bValid_ff;
   assign s_axi_bresp   = bResp_ff;
   assign s_axi_arready = arReady_ff;
   assign s_axi_rvalid  = rValid_ff;
   assign s_axi_rdata   = rData_ff;
   assign s_axi_rresp   = rResp_ff;
   assign rampCount     = rampCnt_ff;
   assign rampPeriod    = period_ff;
   assign rampWrap      = rampWrap_ff;
   assign rampPhaseTick = phaseTick_ff;
   assign rampAmplitude = rampAmp_ff;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstSync_n);

   a_wrap_zero_count: assert property (rampWrap_ff |-> rampCnt_ff == 10'h000)
      else $error("Ramp wrap without count restart.");
   a_audio_sync_restart: assert property (
      phaseReg_ff[`RPSSC_AUDIO_SYNC_BIT] && audioSync |=> rampCnt_ff == 10'h000 && rampWrap_ff)
      else $error("Audio sync did not restart ramp.");
   a_ramp_sync_restart: assert property (
      phaseReg_ff[`RPSSC_RAMP_SYNC_BIT] && rampSyncIn |=> rampCnt_ff == 10'h000 && rampWrap_ff)
      else $error("Ramp sync did not restart ramp.");
   a_no_sync_ignored: assert property (
      phaseReg_ff[1:0] == 2'h0 && (audioSync || rampSyncIn) && srcTick && !endOfRamp
      |=> rampCnt_ff == $past(rampCnt_ff) + 10'h001)
      else $error("Ramp restarted with sync disabled.");
   a_phase_tick_point: assert property (
      phaseTick_ff |-> $past(rampCnt_ff) == phasePoint($past(period_ff), $past(phaseSel)))
      else $error("Phase tick off its quarter point.");
   a_fixed_period: assert property (rampWrap_ff && !$past(manual) && $past(spreadOff)
      && $past(spreadOff, 2) |-> period_ff == `RPSSC_NOM_PERIOD)
      else $error("Unspread period not nominal.");
   a_manual_divisor: assert property (
      rampWrap_ff && $past(manual) && $past(spreadOff) && $past(spreadOff, 2)
      |-> period_ff == clampPeriod({2'h0, $past(divisorReg_ff)}))
      else $error("Manual period differs from divisor.");
   a_prediv_rate: assert property (
      $past(halfRate) && $past(halfRate, 2) && !$past(anySync) && !$past(anySync, 2)
      && $changed(rampCnt_ff) |-> $past(rampCnt_ff) == $past(rampCnt_ff, 2))
      else $error("Pre-divided ramp advanced on consecutive cycles.");
   a_manual_amplitude: assert property (
      manual ##1 manual |-> rampAmp_ff == $past(ampBndReg_ff[`RPSSC_AMP_HI:`RPSSC_AMP_LO]))
      else $error("Manual amplitude not applied.");
   a_tri_within_limit: assert property (
      triOn && $stable(limit) && $past(triOff_ff) <= $past(limit) |-> triOff_ff <= limit)
      else $error("Triangle offset beyond its limit.");
   a_random_span: assert property (
      !rdmOn |=> rndOff_ff == 7'h00)
      else $error("Random offset with random spread off.");
   a_write_answer: assert property (doWrite |=> bValid_ff && !awReady_ff)
      else $error("Write took no response.");

   c_wrap: cover property (rampWrap_ff ##1 !rampWrap_ff);
   c_phase3_tick: cover property (phaseSel == 2'h3 && phaseTick_ff);
   c_tri_turn: cover property (dir_ff == RPSSC_SWEEP_UP ##1 dir_ff == RPSSC_SWEEP_DOWN);
   c_write_done: cover property (bValid_ff && s_axi_bready);
endmodule

//--- logic/rpssc_cfg.svh
`ifndef RPSSC_CFG_SVH
`define RPSSC_CFG_SVH

// Register indices; byte address is four times the index.
`define RPSSC_IDX_PHASE      10'h06A
`define RPSSC_IDX_MODE       10'h06B
`define RPSSC_IDX_RANGE      10'h06C
`define RPSSC_IDX_DIVISOR    10'h06D
`define RPSSC_IDX_STEP       10'h06E
`define RPSSC_IDX_AMPBND     10'h06F
`define RPSSC_IDX_STATUS     10'h080

// Reset values.
`define RPSSC_RST_PHASE      8'h00
`define RPSSC_RST_MODE       8'h00
`define RPSSC_RST_RANGE      8'h00
`define RPSSC_RST_DIVISOR    8'h50
`define RPSSC_RST_STEP       8'h11
`define RPSSC_RST_AMPBND     8'h24

// Field positions.
`define RPSSC_PHASE_SEL_HI   3
`define RPSSC_PHASE_SEL_LO   2
`define RPSSC_AUDIO_SYNC_BIT 1
`define RPSSC_RAMP_SYNC_BIT  0
`define RPSSC_PREDIV_BIT     5
`define RPSSC_MANUAL_BIT     4
`define RPSSC_RANDOM_BIT     1
`define RPSSC_TRIANGLE_BIT   0
`define RPSSC_RDM_RANGE_HI   6
`define RPSSC_RDM_RANGE_LO   4
`define RPSSC_TRI_CTRL_HI    3
`define RPSSC_TRI_CTRL_LO    0
`define RPSSC_FALL_STEP_HI   7
`define RPSSC_FALL_STEP_LO   4
`define RPSSC_RISE_STEP_HI   3
`define RPSSC_RISE_STEP_LO   0
`define RPSSC_AMP_HI         6
`define RPSSC_AMP_LO         5
`define RPSSC_LIMIT_HI       4
`define RPSSC_LIMIT_LO       0

// Ramp timing in source clock ticks, plus reference rate in Hz, default amplitude and LFSR seed.
`define RPSSC_MANUAL_REF_HZ  61440000
`define RPSSC_NOM_PERIOD     10'h050
`define RPSSC_MIN_PERIOD     10'h002
`define RPSSC_AUTO_AMP       2'h1
`define RPSSC_LFSR_SEED      16'hACE1

// Bus answers.
`define RPSSC_RESP_OKAY      2'h0
`define RPSSC_RESP_SLVERR    2'h2

`endif

//--- logic/rpssc_pkg.sv
package rpssc_pkg;
   typedef enum logic [0:0] {
      RPSSC_SWEEP_UP   = 1'b0,
      RPSSC_SWEEP_DOWN = 1'b1
   } rpssc_dir_t;
   typedef logic [9:0] rpssc_period_t;
endpackage

//--- logic/rpssc_lfsr.sv
`timescale 1ns/10ps
`include "rpssc_cfg.svh"
module rpssc_lfsr
   import rpssc_pkg::*;
(
   // Clock and reset.
   input  wire logic       sys_clk,
   input  wire logic       rstSync_n,
   // Control.
   input  wire logic       advance,
   // Random word.
   output logic     [6:0]  randWord
);
   logic [15:0] lfsr_ff;

   // Maximal-length Fibonacci taps 16,14,13,11.
   always_ff @(posedge sys_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         lfsr_ff <= `RPSSC_LFSR_SEED;
      end else if (advance) begin
         lfsr_ff <= {lfsr_ff[14:0], lfsr_ff[15] ^ lfsr_ff[13] ^ lfsr_ff[12] ^ lfsr_ff[10]};
      end
   end

   assign randWord = lfsr_ff[6:0];
endmodule

//--- test/rpssc_top_bench.sv
`timescale 1ns/10ps
module rpssc_top_bench;
   import rpssc_pkg::*;
   typedef struct {
      logic [9:0]  idx;
      logic [31:0] data;
      logic [3:0]  strb;
      logic [7:0]  expRd;
      logic [1:0]  expResp;
   } rpssc_row_t;
   logic             sys_clk;
   logic             arst_n;
   logic             audioSync;
   logic             rampSyncIn;
   logic [11:0]      s_axi_awaddr;
   logic [11:0]      s_axi_araddr;
   logic             s_axi_awvalid;
   logic             s_axi_wvalid;
   logic             s_axi_bready;
   logic             s_axi_arvalid;
   logic             s_axi_rready;
   logic [31:0]      s_axi_wdata;
   logic [3:0]       s_axi_wstrb;
   wire logic        s_axi_awready;
   wire logic        s_axi_wready;
   wire logic        s_axi_bvalid;
   wire logic        s_axi_arready;
   wire logic        s_axi_rvalid;
   wire logic        rampWrap;
   wire logic        rampPhaseTick;
   wire logic [1:0]  s_axi_bresp;
   wire logic [1:0]  s_axi_rresp;
   wire logic [1:0]  rampAmplitude;
   wire logic [31:0] s_axi_rdata;
   wire logic [9:0]  rampCount;
   wire logic [9:0]  rampPeriod;
   int               n_fail;
   int               n_compared;
   int               cycles;
   int               gap;
   int               lo;
   int               hi;
   logic [1:0]       resp;
   logic [31:0]      rd;
   logic [7:0]       cfgVal [6];
   rpssc_row_t       rows [7];

   rpssc_top i_dut (.sys_clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .audioSync, .rampSyncIn, .rampCount,
      .rampPeriod, .rampWrap, .rampPhaseTick, .rampAmplitude);

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   task automatic report_and_stop;
      $display("compared %0d, failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // A hang anywhere ends here; the whole run needs well under this many cycles.
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 80000) begin
         n_fail++;
         report_and_stop();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask

   task automatic axi_wr(input logic [9:0] idx, input logic [31:0] data, input logic [3:0] strb);
      @(posedge sys_clk);
      s_axi_awaddr  <= {idx, 2'h0};
      s_axi_awvalid <= 1'b1;
      s_axi_wdata   <= data;
      s_axi_wstrb   <= strb;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic axi_rd(input logic [9:0] idx);
      @(posedge sys_clk);
      s_axi_araddr  <= {idx, 2'h0};
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   task automatic cfg;
      for (int i = 0; i < 6; i++) begin
         axi_wr(10'h06A + 10'(i), {24'h0, cfgVal[i]}, 4'hF);
      end
   endtask

   task automatic next_wrap(output int n);
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (rampWrap !== 1'b1 && n < 4000);
   endtask

   // Sixteen periods are enough for a step-one sweep to touch both ends.
   task automatic spread_run;
      lo = 1024;
      hi = 0;
      repeat (16) begin
         next_wrap(gap);
         if (int'(rampPeriod) < lo) lo = int'(rampPeriod);
         if (int'(rampPeriod) > hi) hi = int'(rampPeriod);
      end
   endtask

   task automatic check_resets;
      cfgVal = '{8'h00, 8'h00, 8'h00, 8'h50, 8'h11, 8'h24};
      for (int i = 0; i < 6; i++) begin
         axi_rd(10'h06A + 10'(i));
         chk(rd, {24'h0, cfgVal[i]});
      end
      chk(32'(rampAmplitude), 32'h1);
      chk(32'(rampPeriod), 32'h50);
   endtask

   initial begin
      arst_n = 1'b0;
      {audioSync, rampSyncIn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hF;
      n_fail = 0;
      n_compared = 0;
      cycles = 0;
      rows = '{'{10'h06A, 32'hABCD12FF, 4'hF, 8'hFF, 2'h0},
               '{10'h06B, 32'h000000A5, 4'hF, 8'hA5, 2'h0},
               '{10'h06C, 32'h0000005A, 4'hF, 8'h5A, 2'h0},
               '{10'h06D, 32'h0000007E, 4'hF, 8'h7E, 2'h0},
               '{10'h06E, 32'h00000000, 4'hE, 8'h11, 2'h0},
               '{10'h06F, 32'h00000081, 4'hF, 8'h81, 2'h0},
               '{10'h070, 32'h00000001, 4'hF, 8'h00, 2'h2}};
      repeat (16) @(posedge sys_clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      check_resets();
      $display("reset values done");
      foreach (rows[i]) begin
         axi_wr(rows[i].idx, rows[i].data, rows[i].strb);
         chk(32'(resp), 32'(rows[i].expResp));
         axi_rd(rows[i].idx);
         chk(rd, {24'h0, rows[i].expRd});
         chk(32'(resp), 32'(rows[i].expResp));
      end
      $display("register table done");
      cfgVal = '{8'h00, 8'h00, 8'h00, 8'h50, 8'h11, 8'h24};
      cfg();
      next_wrap(gap);
      next_wrap(gap);
      chk(32'(gap), 32'h50);
      cfgVal = '{8'h00, 8'h10, 8'h00, 8'h20, 8'h11, 8'h40};
      cfg();
      next_wrap(gap);
      next_wrap(gap);
      chk(32'(gap), 32'h20);
      chk(32'(rampAmplitude), 32'h2);
      cfgVal[1] = 8'h30;
      cfg();
      next_wrap(gap);
      next_wrap(gap);
      chk(32'(gap), 32'h40);
      $display("fixed and manual periods done");
      cfgVal[1] = 8'h10;
      for (int s = 0; s < 4; s++) begin
         cfgVal[0] = 8'(s << 2);
         cfg();
         next_wrap(gap);
         for (int n = 0; n < 100 && rampPhaseTick !== 1'b1; n++) @(posedge sys_clk);
         chk(32'(rampCount), 32'(8 * s + 1));
      end
      $display("phase select done");
      for (int p = 0; p < 4; p++) begin
         cfgVal[0] = 8'(p);
         cfg();
         for (int w = 0; w < 2; w++) begin
            next_wrap(gap);
            repeat (5) @(posedge sys_clk);
            if (w == 0) rampSyncIn <= 1'b1;
            else audioSync <= 1'b1;
            @(posedge sys_clk);
            rampSyncIn <= 1'b0;
            audioSync <= 1'b0;
            @(posedge sys_clk);
            chk(32'(rampWrap), 32'(p >> w & 1));
            if (p >> w & 1) chk(32'(rampCount), 32'h0);
         end
      end
      $display("sync done");
      cfgVal[0] = 8'h00;
      cfgVal[1] = 8'h12;
      for (int r = 0; r < 8; r++) begin
         cfgVal[2] = 8'(r << 4);
         cfg();
         next_wrap(gap);
         spread_run();
         chk(32'(lo >= 32 && hi > 32 && hi <= 32 + (r < 7 ? (2 << r) - 1 : 127)), 32'h1);
      end
      $display("random spread done");
      cfgVal = '{8'h00, 8'h11, 8'h00, 8'h20, 8'h11, 8'h23};
      cfg();
      next_wrap(gap);
      spread_run();
      chk(32'(lo), 32'h20);
      chk(32'(hi), 32'h23);
      $display("triangle spread done");
      arst_n <= 1'b0;
      repeat (16) @(posedge sys_clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      check_resets();
      $display("second reset done");
      report_and_stop();
   end
endmodule
